/* rtl/ssp_pkg.sv */
// ****************************************************************************
// Functional notes
// - All clock polarity and phase settings supported.
// - Bytes shift most significant bit first.
// - Serial clock at most 20 MHz.
// - Ready low: cycle done, status loaded.
// - Ready high within 10 ms of select.
// - Ready low within 10 ms, status buffered.
// - Variable second block framed as own cycle.
// - Writes to locked areas are refused.
// - Sync serial input writes restart validity timer.
// - Byte write block: command, address, data, mask.
// - Command 0x01 low byte, 0x02 high byte.
// - Only masked bits take the data byte.
// - Reply carries status of the previous access.
// - Command 0x00 changes nothing, fetches status.
// - Status byte, error code, two spare bytes.
// - Failure places its error code after status.
// ****************************************************************************

`default_nettype none

package ssp_pkg;

  // ************************************************************************
  // Block framing
  // ************************************************************************
  localparam int unsigned BLK_BITS  = 32'h0000_0028;
  localparam int unsigned CNT_W     = 32'h0000_0006;
  localparam logic [5:0]  CNT_FULL  = 6'h28;
  localparam logic [5:0]  LAST_BIT  = 6'h27;

  // ************************************************************************
  // Commands, status codes and error codes
  // ************************************************************************
  localparam logic [7:0]  CMD_NOP           = 8'h00;
  localparam logic [7:0]  CMD_WR_LOW        = 8'h01;
  localparam logic [7:0]  CMD_WR_HIGH       = 8'h02;
  localparam logic [7:0]  STAT_NONE         = 8'h00;
  localparam logic [7:0]  STAT_WRITE_OK     = 8'h01;
  localparam logic [7:0]  STAT_WRITE_FAILED = 8'h02;
  localparam logic [15:0] ERR_NONE          = 16'h0000;
  localparam logic [15:0] ERR_LOCKED        = 16'h0001;
  localparam logic [15:0] ERR_BAD_CMD       = 16'h0002;
  localparam logic [15:0] ERR_FRAME         = 16'h0003;
  localparam logic [15:0] ERR_BANK          = 16'h0004;
  localparam logic [15:0] ERR_TIMEOUT       = 16'h0005;
  localparam logic [15:0] SPARE_ZERO        = 16'h0000;

  // ************************************************************************
  // Register areas; index 0 is the sync serial input area, the others are closed to writes.
  // ************************************************************************
  localparam int unsigned AREA_N    = 32'h0000_0006;
  localparam int unsigned AREA_SSC  = 32'h0000_0000;
  localparam logic [15:0] AREA_LO [AREA_N] = '{16'h1001, 16'h1401, 16'h2401,
                                                16'h2801, 16'h1801, 16'h1C01};
  localparam logic [15:0] AREA_HI [AREA_N] = '{16'h1400, 16'h1500, 16'h2800,
                                                16'h2C00, 16'h1C00, 16'h2000};
  localparam logic [AREA_N-1:0] AREA_LOCK = 6'h3E;

  // ************************************************************************
  // Timing
  // ************************************************************************
  localparam int unsigned REF_CLK_KHZ   = 32'h0000_2710;
  localparam int unsigned SCK_MAX_KHZ   = 32'h0000_4E20;
  localparam int unsigned READY_MAX_MS  = 32'h0000_000A;
  localparam int unsigned READY_MAX_CYC = READY_MAX_MS * REF_CLK_KHZ;
  localparam int unsigned EXEC_SLACK    = 32'h0000_0008;

  // ************************************************************************
  // Carriers and states
  // ************************************************************************
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  mask;
  } ssp_blk_s;

  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] err;
    logic [15:0] spare;
  } ssp_stat_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_OPEN,
    ST_EXEC,
    ST_BANK
  } ssp_state_e;

endpackage : ssp_pkg

`default_nettype wire

/* rtl/ssp_spi_slave.sv */
`default_nettype none

module ssp_spi_slave #(
  parameter int unsigned READY_MAX_CYC = ssp_pkg::READY_MAX_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CFG_CPOL,
  input  wire logic        CFG_CPHA,
  input  wire logic        SPI_SCK,
  input  wire logic        SPI_CS,
  input  wire logic        SPI_MOSI,
  output logic             SPI_MISO,
  output logic             SPI_READY,
  output logic             RB_REQ,
  output logic [15:0]      RB_ADDR,
  output logic [15:0]      RB_WDATA,
  output logic [15:0]      RB_WMASK,
  input  wire logic        RB_ACK,
  input  wire logic        RB_ERR,
  output logic             SSC_VALID_RESTART
);

  // ************************************************************************
  // Constants and helpers
  // ************************************************************************
  localparam int unsigned WAIT_LIMIT = READY_MAX_CYC - ssp_pkg::EXEC_SLACK;
  localparam int unsigned WAIT_W     = $clog2(READY_MAX_CYC + 1);
  localparam logic [WAIT_W-1:0] WAIT_END = WAIT_W'(WAIT_LIMIT);

  function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_area = (a >= lo) && (a <= hi);
  endfunction

  // ************************************************************************
  // Reset and select synchronisers
  // ************************************************************************
  logic [1:0] rst_sync_q;
  logic [1:0] cs_sync_q;
  logic       rst_n;
  logic       cs_on;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_q <= 2'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], SPI_CS};
    end
  end

  assign cs_on = cs_sync_q[1];

  // ************************************************************************
  // Link domain
  // ************************************************************************
  // The polarity and phase straps are folded into one sampling clock: data
  // is taken on its rising edge and the reply advances on its falling edge.
  // The straps are static configuration and must not change in operation.
  logic                     sample_clk;
  logic                     clr_q;
  logic                     link_clr_n;
  logic [ssp_pkg::CNT_W-1:0] rx_cnt_q;
  logic [ssp_pkg::CNT_W-1:0] tx_idx_q;
  logic [ssp_pkg::BLK_BITS-1:0] rx_shift_q;
  logic                     rx_take;
  logic [ssp_pkg::CNT_W-1:0] tx_bit;
  ssp_pkg::ssp_stat_s        tx_stat_q;

  assign sample_clk = SPI_SCK ^ CFG_CPOL ^ CFG_CPHA;
  assign link_clr_n = ~clr_q;
  assign rx_take    = SPI_CS && (rx_cnt_q != ssp_pkg::CNT_FULL);

  always_ff @(posedge sample_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      rx_cnt_q <= '0;
    end else if (rx_take) begin
      rx_cnt_q <= rx_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sample_clk) begin
    if (rx_take) begin
      rx_shift_q <= {rx_shift_q[ssp_pkg::BLK_BITS-2:0], SPI_MOSI};
    end
  end

  // The reply index follows the count of bits taken, so in phase 1 the
  // leading edge does not advance it and the first bit stays on the line.
  always_ff @(negedge sample_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      tx_idx_q <= '0;
    end else begin
      tx_idx_q <= rx_cnt_q;
    end
  end

  assign tx_bit = ssp_pkg::LAST_BIT - tx_idx_q;

  // The reply bit is selected from the held status word: the first bit must
  // stand on the line before any clock edge, which no link flop can give.
  assign SPI_MISO = (tx_idx_q < ssp_pkg::CNT_FULL) ? tx_stat_q[tx_bit] : 1'b0;

  // ************************************************************************
  // Block decode
  // ************************************************************************
  ssp_pkg::ssp_blk_s blk_q;
  logic              len_ok_q;
  logic [ssp_pkg::AREA_N-1:0] area_hit;
  logic              is_nop;
  logic              is_low;
  logic              is_high;
  logic              is_wr;
  logic              locked;
  logic              ssc_hit;
  logic              go_bank;

  genvar gi;
  generate
    for (gi = 0; gi < ssp_pkg::AREA_N; gi++) begin : g_area
      assign area_hit[gi] = in_area(blk_q.addr, ssp_pkg::AREA_LO[gi], ssp_pkg::AREA_HI[gi]);
    end
  endgenerate

  assign is_nop  = blk_q.cmd == ssp_pkg::CMD_NOP;
  assign is_low  = blk_q.cmd == ssp_pkg::CMD_WR_LOW;
  assign is_high = blk_q.cmd == ssp_pkg::CMD_WR_HIGH;
  assign is_wr   = is_low || is_high;
  assign locked  = |(area_hit & ssp_pkg::AREA_LOCK);
  assign ssc_hit = area_hit[ssp_pkg::AREA_SSC];
  assign go_bank = len_ok_q && is_wr && !locked;

  // ************************************************************************
  // Control state machine
  // ************************************************************************
  ssp_pkg::ssp_state_e state_q;
  ssp_pkg::ssp_state_e state_d;
  logic [WAIT_W-1:0]   wait_q;
  logic                wait_over;
  logic                bank_done;
  logic                stat_load;
  ssp_pkg::ssp_stat_s  exec_stat;
  ssp_pkg::ssp_stat_s  bank_stat;
  ssp_pkg::ssp_stat_s  stat_d;

  assign wait_over = wait_q == WAIT_END;
  assign bank_done = (state_q == ssp_pkg::ST_BANK) && (RB_ACK || wait_over);
  assign stat_load = ((state_q == ssp_pkg::ST_EXEC) && !go_bank) || bank_done;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ssp_pkg::ST_IDLE: begin
        if (cs_on) begin
          state_d = ssp_pkg::ST_OPEN;
        end
      end
      ssp_pkg::ST_OPEN: begin
        if (!cs_on) begin
          state_d = ssp_pkg::ST_EXEC;
        end
      end
      ssp_pkg::ST_EXEC: begin
        state_d = go_bank ? ssp_pkg::ST_BANK : ssp_pkg::ST_IDLE;
      end
      ssp_pkg::ST_BANK: begin
        if (RB_ACK || wait_over) begin
          state_d = ssp_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ************************************************************************
  // Status selection
  // ************************************************************************
  // A no-operation block leaves the pending status in place, so a later
  // no-operation still returns the result of the last real access.
  assign exec_stat = !len_ok_q ? '{ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_FRAME, ssp_pkg::SPARE_ZERO} :
                     is_nop    ? tx_stat_q :
                     !is_wr    ? '{ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_BAD_CMD, ssp_pkg::SPARE_ZERO} :
                                 '{ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_LOCKED, ssp_pkg::SPARE_ZERO};

  assign bank_stat = !RB_ACK ? '{ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_TIMEOUT, ssp_pkg::SPARE_ZERO} :
                     RB_ERR  ? '{ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_BANK, ssp_pkg::SPARE_ZERO} :
                               '{ssp_pkg::STAT_WRITE_OK, ssp_pkg::ERR_NONE, ssp_pkg::SPARE_ZERO};

  assign stat_d = bank_done ? bank_stat : exec_stat;

  // ************************************************************************
  // Registers
  // ************************************************************************
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ssp_pkg::ST_IDLE;
      clr_q   <= 1'b1;
      SPI_READY <= 1'b0;
    end else begin
      state_q <= state_d;
      clr_q   <= state_d == ssp_pkg::ST_IDLE;
      SPI_READY <= state_d != ssp_pkg::ST_IDLE;
    end
  end

  // The link side is idle once select has been seen low, so the shift
  // register and bit count are stable when this domain copies them.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      blk_q    <= '0;
      len_ok_q <= 1'b0;
    end else if ((state_q == ssp_pkg::ST_OPEN) && !cs_on) begin
      blk_q    <= rx_shift_q;
      len_ok_q <= rx_cnt_q == ssp_pkg::CNT_FULL;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_stat_q <= '{ssp_pkg::STAT_NONE, ssp_pkg::ERR_NONE, ssp_pkg::SPARE_ZERO};
    end else if (stat_load) begin
      tx_stat_q <= stat_d;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= '0;
    end else if (state_q == ssp_pkg::ST_BANK) begin
      wait_q <= wait_q + 1'b1;
    end else begin
      wait_q <= '0;
    end
  end

  // ************************************************************************
  // Register bank port
  // ************************************************************************
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RB_REQ   <= 1'b0;
      RB_ADDR  <= '0;
      RB_WDATA <= '0;
      RB_WMASK <= '0;
    end else if ((state_q == ssp_pkg::ST_EXEC) && go_bank) begin
      RB_REQ   <= 1'b1;
      RB_ADDR  <= blk_q.addr;
      RB_WDATA <= {blk_q.data, blk_q.data};
      RB_WMASK <= is_high ? {blk_q.mask, 8'h00} : {8'h00, blk_q.mask};
    end else if (bank_done) begin
      RB_REQ   <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SSC_VALID_RESTART <= 1'b0;
    end else begin
      SSC_VALID_RESTART <= bank_done && RB_ACK && !RB_ERR && ssc_hit;
    end
  end

endmodule : ssp_spi_slave

`default_nettype wire

/* bench/ssp_spi_slave_asserts.sv */
`default_nettype none

module ssp_slave_chk #(
  parameter int unsigned READY_MAX_CYC = 64
) (
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        SPI_CS,
  input wire logic        SPI_READY,
  input wire logic        RB_REQ,
  input wire logic [15:0] RB_ADDR,
  input wire logic [15:0] RB_WDATA,
  input wire logic [15:0] RB_WMASK,
  input wire logic        RB_ACK,
  input wire logic        RB_ERR,
  input wire logic        SSC_VALID_RESTART
);
  timeunit 1ns;
  timeprecision 1ps;
  // **********
  // Handshake and bank port checks
  // **********
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  logic [31:0] busy_q;
  logic [31:0] busy_d;
  // Counting cycles keeps the long processing bound out of the property unroller.
  assign busy_d = (SPI_READY && !SPI_CS) ? busy_q + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) busy_q <= 32'h0000_0000;
    else busy_q <= busy_d;
  end
  chk_ready_open: assert property ($rose(SPI_CS) |-> ##[1:4] SPI_READY)
    else $error("ready late after select");
  chk_ready_keep: assert property (SPI_READY && SPI_CS |=> SPI_READY)
    else $error("ready dropped during block");
  chk_idle_low: assert property (!SPI_READY && !SPI_CS |=> !SPI_READY)
    else $error("ready rose without select");
  chk_busy_bound: assert property (busy_q <= READY_MAX_CYC)
    else $error("block processing too long");
  chk_req_stable: assert property (RB_REQ && $past(RB_REQ) |-> $stable({RB_ADDR, RB_WDATA, RB_WMASK}))
    else $error("bank request changed while pending");
  chk_ack_ends: assert property (RB_REQ && RB_ACK |=> !RB_REQ && !SPI_READY)
    else $error("ack did not close the block");
  chk_no_locked: assert property (RB_REQ |-> !(RB_ADDR inside {[16'h1401:16'h1500], [16'h1801:16'h2000],
                                                              [16'h2401:16'h2C00]}))
    else $error("write to locked area reached bank");
  chk_byte_lane: assert property (RB_REQ |-> RB_WDATA[15:8] == RB_WDATA[7:0] &&
                                  (RB_WMASK[15:8] == 8'h00 || RB_WMASK[7:0] == 8'h00))
    else $error("byte lane or mask malformed");
  chk_ssc_restart: assert property (RB_REQ && RB_ACK && !RB_ERR && (RB_ADDR inside {[16'h1001:16'h1400]})
                                    |=> SSC_VALID_RESTART ##1 !SSC_VALID_RESTART)
    else $error("validity restart pulse missing");
  chk_ssc_cause: assert property ($rose(SSC_VALID_RESTART) |-> $past(RB_REQ && RB_ACK && !RB_ERR) &&
                                  ($past(RB_ADDR) inside {[16'h1001:16'h1400]}))
    else $error("validity restart without cause");
  cov_open: cover property ($rose(SPI_READY));
  cov_bank: cover property (RB_REQ && RB_ACK && RB_ERR);
  cov_ssc: cover property (SSC_VALID_RESTART);
  cov_timeout: cover property (RB_REQ && !RB_ACK ##1 !RB_REQ);
endmodule // ssp_slave_chk

bind ssp_spi_slave ssp_slave_chk #(.READY_MAX_CYC(READY_MAX_CYC)) i_chk (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SPI_CS(SPI_CS), .SPI_READY(SPI_READY), .RB_REQ(RB_REQ),
  .RB_ADDR(RB_ADDR), .RB_WDATA(RB_WDATA), .RB_WMASK(RB_WMASK), .RB_ACK(RB_ACK), .RB_ERR(RB_ERR),
  .SSC_VALID_RESTART(SSC_VALID_RESTART));

`default_nettype wire

/* bench/ssp_master_mdl.sv */
`default_nettype none

module ssp_master_mdl (
  input  wire logic        clk,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic        miso,
  input  wire logic        ready,
  output logic             sck,
  output logic             cs,
  output logic             mosi,
  output logic             rx_vld,
  output logic [39:0]      rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;
  logic hung;
  // **********
  // Serial master
  // **********
  // The clock rests at the polarity level, so it stands still between frames.
  assign sck = ph ^ cpol;
  initial begin
    ph = 1'b0;
    cs = 1'b0;
    mosi = 1'b0;
    rx_vld = 1'b0;
    rx_data = 40'h00_0000_0000;
    hung = 1'b0;
  end
  task automatic wait_rdy(input logic lvl);
    int n;
    n = 0;
    while (ready !== lvl && n < 200) begin
      @(posedge clk);
      #2 n++;
    end
    if (n == 200) hung = 1'b1;
  endtask
  task automatic xfer(input logic [39:0] tx, input int nb);
    @(posedge clk);
    rx_data = 40'h00_0000_0000;
    #2 cs = 1'b1;
    wait_rdy(1'b1);
    #7;
    for (int i = 39; i > 39 - nb; i--) begin
      if (!cpha) begin
        mosi = tx[i];
        #8 rx_data[i] = miso;
        ph = 1'b1;
        #16 ph = 1'b0;
        #8;
      end else begin
        #8 ph = 1'b1;
        #1 mosi = tx[i];
        #15 rx_data[i] = miso;
        ph = 1'b0;
        #8;
      end
    end
    mosi = ~mosi;
    @(posedge clk);
    #2 cs = 1'b0;
    wait_rdy(1'b0);
    rx_vld = 1'b1;
    @(posedge clk);
    #2 rx_vld = 1'b0;
  endtask
endmodule // ssp_master_mdl

`default_nettype wire

/* bench/testbench.sv */
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset_n, cpol, cpha, rb_ack, rb_err, sck, cs, mosi, miso, rdy, rb_req, sync_serial_port, rx_vld, req_d;
  logic [15:0] rb_addr, rb_wdata, rb_wmask, a;
  logic [39:0] rx_data;
  logic [7:0]  d, m;
  logic [47:0] exp_rb[$];
  logic [39:0] exp_st[$];
  int          error_cnt, samples_checked;
  logic        hold_ack;
  int          nb;
  integer      seed = 32'h9107_9c35;
  // **********
  // Device and partner
  // **********
  // A small limit shortens the bank timeout so a hung bank shows within the run.
  ssp_spi_slave #(.READY_MAX_CYC(64)) i_dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .CFG_CPOL(cpol), .CFG_CPHA(cpha), .SPI_SCK(sck), .SPI_CS(cs),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_READY(rdy), .RB_REQ(rb_req), .RB_ADDR(rb_addr),
    .RB_WDATA(rb_wdata), .RB_WMASK(rb_wmask), .RB_ACK(rb_ack), .RB_ERR(rb_err), .SSC_VALID_RESTART(sync_serial_port));
  ssp_master_mdl i_mst (.clk(ref_clk), .cpol(cpol), .cpha(cpha), .miso(miso), .ready(rdy), .sck(sck),
    .cs(cs), .mosi(mosi), .rx_vld(rx_vld), .rx_data(rx_data));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic judge(input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_rb(input logic [47:0] g);
    judge(exp_rb.size() ? exp_rb.pop_front() : {48{1'bx}}, g);
  endtask
  task automatic cmp_st(input logic [39:0] g);
    judge(exp_st.size() ? {8'h00, exp_st.pop_front()} : {48{1'bx}}, {8'h00, g});
  endtask
  // **********
  // Bank responder and result watch
  // **********
  always @(posedge ref_clk) begin
    if (rb_req && !req_d) cmp_rb({rb_addr, rb_wdata, rb_wmask});
    if (rx_vld) cmp_st(rx_data);
    req_d = rb_req;
    #2 rb_ack = rb_req && !rb_ack && !hold_ack && ($random(seed) % 3 == 0);
  end
  task automatic blk(input logic [39:0] tx, input logic [7:0] sc, input logic [15:0] er);
    exp_st.push_back({sc, er, ssp_pkg::SPARE_ZERO});
    i_mst.xfer(tx, nb);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400us;
    error_cnt++;
    close_out;
  end
  initial begin
    {reset_n, cpol, cpha, rb_ack, rb_err, req_d} = 6'h00;
    hold_ack = 1'b0;
    nb = 40;
    error_cnt = 0;
    samples_checked = 0;
    for (int md = 0; md < 4; md++) begin
      #2 reset_n = 1'b0;
      {cpol, cpha} = md[1:0];
      repeat (3) @(posedge ref_clk);
      #2 reset_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      a = 16'h1001 + 16'($random(seed) & 32'h0000_03FF);
      d = 8'($random(seed));
      m = 8'($random(seed));
      blk({ssp_pkg::CMD_NOP, a, d, m}, ssp_pkg::STAT_NONE, ssp_pkg::ERR_NONE);
      exp_rb.push_back({a, d, d, 8'h00, m});
      blk({ssp_pkg::CMD_WR_LOW, a, d, m}, ssp_pkg::STAT_NONE, ssp_pkg::ERR_NONE);
      rb_err = 1'b1;
      a = 16'($random(seed) & 32'h0000_0FFF);
      exp_rb.push_back({a, d, d, m, 8'h00});
      blk({ssp_pkg::CMD_WR_HIGH, a, d, m}, ssp_pkg::STAT_WRITE_OK, ssp_pkg::ERR_NONE);
      rb_err = 1'b0;
      blk({ssp_pkg::CMD_WR_LOW, md[0] ? ssp_pkg::AREA_HI[md + 1] : ssp_pkg::AREA_LO[md + 1], d, m},
          ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_BANK);
      blk({8'h04, a, d, m}, ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_LOCKED);
      blk({ssp_pkg::CMD_NOP, a, d, m}, ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_BAD_CMD);
      blk({ssp_pkg::CMD_NOP, a, d, m}, ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_BAD_CMD);
      // A silent bank lets the wait run out, so the timeout reply is seen.
      hold_ack = 1'b1;
      exp_rb.push_back({a, d, d, 8'h00, m});
      blk({ssp_pkg::CMD_WR_LOW, a, d, m}, ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_BAD_CMD);
      hold_ack = 1'b0;
      nb = 32;
      blk({ssp_pkg::CMD_NOP, a, d, m}, ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_TIMEOUT);
      nb = 40;
      blk({ssp_pkg::CMD_NOP, a, d, m}, ssp_pkg::STAT_WRITE_FAILED, ssp_pkg::ERR_FRAME);
    end
    if (exp_rb.size() != 0 || exp_st.size() != 0 || i_mst.hung !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] %0t left %h %h", $time, exp_rb.size(), exp_st.size());
    end
    close_out;
  end
endmodule // testbench

`default_nettype wire
